// *** analog_word_pkg.sv ***
package analog_word_pkg;

  // word layout
  localparam int unsigned DATA_W   = 12;
  localparam int unsigned MAG_W    = 11;
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned SIGN_BIT = 11;
  localparam int unsigned LOS_BIT  = 15;
  localparam int unsigned GAP_LO   = 12;
  localparam int unsigned GAP_HI   = 14;

  // conversion limits
  localparam logic [DATA_W-1:0] FULL_SCALE = 12'h0_FFF;
  localparam logic [MAG_W-1:0]  MAG_MAX    = 11'h7_FF;
  localparam logic [DATA_W-1:0] NEG_LIMIT  = 12'h8_00;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  // loss-of-signal detection levels (mV for voltage, uA for current)
  localparam logic [WORD_W-1:0] LOS_LEVEL_MV = 16'h01F4;
  localparam logic [WORD_W-1:0] LOS_LEVEL_UA = 16'h07D0;

  // input ranges
  typedef enum logic [2:0] {
    RNG_1_5V  = 3'b000,
    RNG_4_20M = 3'b001,
    RNG_0_10V = 3'b010,
    RNG_0_5V  = 3'b011,
    RNG_PM10V = 3'b100,
    RNG_PM5V  = 3'b101
  } range_t;

  // one converted sample from the converter side
  typedef struct packed {
    logic              valid;
    logic              point;  // 0 = input point 1, 1 = input point 2
    logic [DATA_W-1:0] code;   // unsigned, or two's complement if bipolar
    logic [WORD_W-1:0] level;  // measured input level, mV or uA
  } sample_t;

  // the two consecutive host input words
  typedef struct packed {
    logic [WORD_W-1:0] pt2;
    logic [WORD_W-1:0] pt1;
  } word_pair_t;

  function automatic logic is_bipolar(input range_t r);
    is_bipolar = (r == RNG_PM10V) || (r == RNG_PM5V);
  endfunction

  function automatic logic has_los(input range_t r);
    has_los = (r == RNG_1_5V) || (r == RNG_4_20M);
  endfunction

endpackage

// *** chan_word_fmt.sv ***
`timescale 1ns/1ps
`default_nettype none

module chan_word_fmt (
  // sample in
  input  wire logic [analog_word_pkg::DATA_W-1:0] code,
  input  wire logic [analog_word_pkg::WORD_W-1:0] level,
  input  wire analog_word_pkg::range_t            rng,
  // formatted word out
  output logic [analog_word_pkg::WORD_W-1:0]      word
);

  logic [analog_word_pkg::DATA_W-1:0] neg;
  logic                               lost;

  // magnitude of a negative sample and loss detection
  always_comb begin
    neg  = -code;
    lost = 1'b0;
    if (rng == analog_word_pkg::RNG_1_5V) begin
      lost = (level <= analog_word_pkg::LOS_LEVEL_MV);
    end else if (rng == analog_word_pkg::RNG_4_20M) begin
      lost = (level <= analog_word_pkg::LOS_LEVEL_UA);
    end
  end

  // assemble the word
  always_comb begin
    word = analog_word_pkg::WORD_RESET;
    if (analog_word_pkg::is_bipolar(rng)) begin
      word[analog_word_pkg::SIGN_BIT] = code[analog_word_pkg::SIGN_BIT];
      if (!code[analog_word_pkg::SIGN_BIT]) begin
        word[analog_word_pkg::MAG_W-1:0] =
          code[analog_word_pkg::MAG_W-1:0];
      end else if (code == analog_word_pkg::NEG_LIMIT) begin
        word[analog_word_pkg::MAG_W-1:0] = analog_word_pkg::MAG_MAX;
      end else begin
        word[analog_word_pkg::MAG_W-1:0] =
          neg[analog_word_pkg::MAG_W-1:0];
      end
    end else begin
      word[analog_word_pkg::DATA_W-1:0] = code;
    end
    // flag only in the live-zero ranges, clear elsewhere
    word[analog_word_pkg::LOS_BIT] =
      analog_word_pkg::has_los(rng) && lost;
  end

endmodule

`default_nettype wire

// *** dual_analog_input_word_format.sv ***
// Overview of operation
// - Unipolar ranges deliver each result as a 12-bit unsigned value.
// - In the 1-5 V / 4-20 mA range bit 15 is set on disconnection.
// - Loss is flagged at or below 0.5 V (voltage) or 2 mA (current).
// - In bipolar mode bit 11 is low for positive, high for negative.
// - Each channel is a 16-bit word, result in bits 0-11, flag in 15.
// - Unipolar full scale is 4095 and is never exceeded.
// - Point 1 goes to the first word and point 2 to the next word.
// - Outside the 1-5 V / 4-20 mA range the flag is always clear.
`timescale 1ns/1ps
`default_nettype none

module dual_analog_input_word_format (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // configuration and converter side
  input  wire analog_word_pkg::range_t       rng,
  input  wire analog_word_pkg::sample_t      smp,
  // host input word area
  output analog_word_pkg::word_pair_t        host_input_word_area,
  output logic                               word_upd
);

  // whole module state
  typedef struct packed {
    analog_word_pkg::word_pair_t words;
    logic                        upd;
    logic                        last_point;
  } st_t;

  st_t                                st_r;
  st_t                                st_nxt;
  logic [analog_word_pkg::WORD_W-1:0] fmt_word;

  // per-sample formatter
  chan_word_fmt u_fmt (
    .code  (smp.code),
    .level (smp.level),
    .rng   (rng),
    .word  (fmt_word)
  );

  // route the formatted word to its point's slot
  always_comb begin
    st_nxt     = st_r;
    st_nxt.upd = 1'b0;
    if (smp.valid) begin
      st_nxt.upd        = 1'b1;
      st_nxt.last_point = smp.point;
      if (smp.point) begin
        st_nxt.words.pt2 = fmt_word;
      end else begin
        st_nxt.words.pt1 = fmt_word;
      end
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign host_input_word_area = st_r.words;
  assign word_upd             = st_r.upd;

  // word last written, for the checks below
  logic [analog_word_pkg::WORD_W-1:0] last_w;
  assign last_w = st_r.last_point ? st_r.words.pt2 : st_r.words.pt1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_take;
    smp.valid;
  endsequence

  sequence s_take_los_v;
    smp.valid && rng == analog_word_pkg::RNG_1_5V;
  endsequence

  sequence s_take_los_i;
    smp.valid && rng == analog_word_pkg::RNG_4_20M;
  endsequence

  sequence s_take_bip;
    smp.valid && analog_word_pkg::is_bipolar(rng);
  endsequence

  // sample offered on each point
  sequence s_take_pt1;
    smp.valid && !smp.point;
  endsequence

  sequence s_take_pt2;
    smp.valid && smp.point;
  endsequence

  // sample in a unipolar range
  sequence s_take_uni;
    smp.valid && !analog_word_pkg::is_bipolar(rng);
  endsequence

  // bipolar sample, positive, and at the negative limit
  sequence s_take_pos;
    s_take_bip ##0 !smp.code[analog_word_pkg::SIGN_BIT];
  endsequence

  sequence s_take_min;
    s_take_bip ##0 (smp.code == analog_word_pkg::NEG_LIMIT);
  endsequence

  // no sample this cycle
  sequence s_idle;
    !smp.valid;
  endsequence

  chk_update_pulse: assert property (s_take |=> word_upd ##1
    (word_upd == $past(smp.valid)))
    else $error("update pulse does not follow a sample");

  chk_los_volt_set: assert property (s_take_los_v ##0
    (smp.level <= analog_word_pkg::LOS_LEVEL_MV) |=>
    last_w[analog_word_pkg::LOS_BIT])
    else $error("voltage loss not flagged");

  chk_los_volt_clr: assert property (s_take_los_v ##0
    (smp.level > analog_word_pkg::LOS_LEVEL_MV) |=>
    !last_w[analog_word_pkg::LOS_BIT])
    else $error("voltage loss flagged while normal");

  chk_los_cur_set: assert property (s_take_los_i ##0
    (smp.level <= analog_word_pkg::LOS_LEVEL_UA) |=>
    last_w[analog_word_pkg::LOS_BIT])
    else $error("current loss not flagged");

  chk_los_other_off: assert property (smp.valid &&
    !analog_word_pkg::has_los(rng) |=> !last_w[analog_word_pkg::LOS_BIT])
    else $error("loss flag set outside live-zero range");

  chk_gap_bits_zero: assert property (s_take |=>
    (last_w[analog_word_pkg::GAP_HI:analog_word_pkg::GAP_LO] == '0))
    else $error("bits 12 to 14 not zero");

  chk_unipolar_data: assert property (smp.valid &&
    !analog_word_pkg::is_bipolar(rng) |=>
    last_w[analog_word_pkg::DATA_W-1:0] == $past(smp.code))
    else $error("unipolar data not passed through");

  chk_bipolar_sign: assert property (s_take_bip |=>
    last_w[analog_word_pkg::SIGN_BIT] ==
    $past(smp.code[analog_word_pkg::SIGN_BIT]))
    else $error("bipolar sign bit wrong");

  chk_bipolar_mag: assert property (s_take_bip ##0
    smp.code[analog_word_pkg::SIGN_BIT] ##0
    (smp.code != analog_word_pkg::NEG_LIMIT) |=>
    {1'b0, last_w[analog_word_pkg::MAG_W-1:0]} == $past(-smp.code))
    else $error("bipolar magnitude wrong");

  chk_point_other: assert property (smp.valid && !smp.point |=>
    $stable(host_input_word_area.pt2))
    else $error("point 1 sample disturbed second word");

  chk_los_cur_clr: assert property (s_take_los_i ##0
    (smp.level > analog_word_pkg::LOS_LEVEL_UA) |=>
    !last_w[analog_word_pkg::LOS_BIT])
    else $error("current loss flagged while normal");

  chk_los_cur_data: assert property (s_take_los_i |=>
    last_w[analog_word_pkg::DATA_W-1:0] == $past(smp.code))
    else $error("current range data lost beside flag");

  chk_bipolar_pos: assert property (s_take_pos |=>
    last_w[analog_word_pkg::MAG_W-1:0] ==
    $past(smp.code[analog_word_pkg::MAG_W-1:0]))
    else $error("bipolar positive data wrong");

  chk_bipolar_sat: assert property (s_take_min |=>
    last_w[analog_word_pkg::MAG_W-1:0] == analog_word_pkg::MAG_MAX)
    else $error("bipolar negative limit not saturated");

  chk_full_scale: assert property (s_take_uni ##0
    (smp.code == analog_word_pkg::FULL_SCALE) |=>
    last_w[analog_word_pkg::DATA_W-1:0] == analog_word_pkg::FULL_SCALE)
    else $error("unipolar full scale not delivered");

  chk_point_one_data: assert property (s_take_pt1 ##0 s_take_uni |=>
    host_input_word_area.pt1[analog_word_pkg::DATA_W-1:0] ==
    $past(smp.code))
    else $error("point 1 sample missing from first word");

  chk_point_two_data: assert property (s_take_pt2 ##0 s_take_uni |=>
    host_input_word_area.pt2[analog_word_pkg::DATA_W-1:0] ==
    $past(smp.code))
    else $error("point 2 sample missing from next word");

  chk_point_two_other: assert property (s_take_pt2 |=>
    $stable(host_input_word_area.pt1))
    else $error("point 2 sample disturbed first word");

  chk_idle_hold: assert property (s_idle |=>
    $stable(host_input_word_area))
    else $error("words changed with no sample");

  chk_idle_no_pulse: assert property (s_idle |=> !word_upd)
    else $error("update pulse with no sample");

  chk_upd_has_take: assert property (word_upd |-> $past(smp.valid))
    else $error("update pulse without a taken sample");

  chk_gap_out_zero: assert property (
    (host_input_word_area.pt1[analog_word_pkg::GAP_HI:analog_word_pkg::GAP_LO]
      == '0) &&
    (host_input_word_area.pt2[analog_word_pkg::GAP_HI:analog_word_pkg::GAP_LO]
      == '0))
    else $error("spare bits set in a host word");

  chk_reset_clear: assert property ($fell(rst) |->
    (host_input_word_area == '0) && !word_upd)
    else $error("outputs not clear after reset");

endmodule

`default_nettype wire

// *** host_reader.sv ***
`timescale 1ns/1ps
`default_nettype none

module host_reader (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // host input word area
  input  wire analog_word_pkg::word_pair_t words,
  input  wire logic                        upd,
  // measured values
  output logic [11:0]                      val1,
  output logic [11:0]                      val2
);
  // keep only the result field, flag and spare bits masked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      val1 <= 12'h000;
      val2 <= 12'h000;
    end else if (upd) begin
      val1 <= words.pt1[11:0];
      val2 <= words.pt2[11:0];
    end
  end
endmodule

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct packed {
    analog_word_pkg::range_t rng;
    logic                    pt;
    logic [11:0]             code;
    logic [15:0]             lvl;
    logic [15:0]             exp;
  } row_t;

  logic                        clk;
  logic                        rst;
  analog_word_pkg::range_t     rng;
  analog_word_pkg::sample_t    smp;
  analog_word_pkg::word_pair_t words;
  logic                        word_upd;
  logic [11:0]                 val1;
  logic [11:0]                 val2;
  logic [15:0]                 expw [2];
  row_t                        rows [10];
  int                          fail_count;
  int                          cmp_count;

  dual_analog_input_word_format u_dut (.clk(clk), .rst(rst), .rng(rng),
    .smp(smp), .host_input_word_area(words), .word_upd(word_upd));
  host_reader u_host (.clk(clk), .rst(rst), .words(words),
    .upd(word_upd), .val1(val1), .val2(val2));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // offer one sample; valid stays up for a back-to-back follower
  task automatic send(input analog_word_pkg::range_t r, input logic p,
                      input logic [11:0] c, input logic [15:0] l);
    rng = r;
    smp = '{1'b1, p, c, l};
    @(negedge clk);
  endtask

  task automatic results();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #100000;
    fail_count++;
    results();
  end

  // main sequence
  initial begin
    fail_count = 0;
    cmp_count = 0;
    rst = 1'b1;
    rng = analog_word_pkg::RNG_1_5V;
    smp = '0;
    expw = '{16'h0000, 16'h0000};
    rows = '{
      '{analog_word_pkg::RNG_1_5V,  1'b0, 12'hfff, 16'h01f4, 16'h8fff},
      '{analog_word_pkg::RNG_1_5V,  1'b1, 12'h123, 16'h01f5, 16'h0123},
      '{analog_word_pkg::RNG_4_20M, 1'b0, 12'h800, 16'h07d0, 16'h8800},
      '{analog_word_pkg::RNG_4_20M, 1'b1, 12'h800, 16'h07d1, 16'h0800},
      '{analog_word_pkg::RNG_0_10V, 1'b0, 12'hfff, 16'h0000, 16'h0fff},
      '{analog_word_pkg::RNG_0_5V,  1'b1, 12'h0a5, 16'h0000, 16'h00a5},
      '{analog_word_pkg::RNG_PM10V, 1'b0, 12'h7ff, 16'h0000, 16'h07ff},
      '{analog_word_pkg::RNG_PM10V, 1'b1, 12'hfff, 16'h0000, 16'h0801},
      '{analog_word_pkg::RNG_PM5V,  1'b0, 12'h800, 16'h0000, 16'h0fff},
      '{analog_word_pkg::RNG_PM5V,  1'b1, 12'hf00, 16'h0000, 16'h0900}};
    repeat (3) @(negedge clk);
    chk(words.pt1 | words.pt2 | {15'h0000, word_upd}, 16'h0000);
    rst = 1'b0;
    @(negedge clk);
    foreach (rows[i]) begin
      send(rows[i].rng, rows[i].pt, rows[i].code, rows[i].lvl);
      smp.valid = 1'b0;
      expw[rows[i].pt] = rows[i].exp;
      chk({15'h0000, word_upd}, 16'h0001);
      chk(words.pt1, expw[0]);
      chk(words.pt2, expw[1]);
      @(negedge clk);
      chk({15'h0000, word_upd}, 16'h0000);
      chk({4'h0, rows[i].pt ? val2 : val1}, {4'h0, rows[i].exp[11:0]});
    end
    // spare range code, low level: plain unsigned, no flag
    send(analog_word_pkg::range_t'(3'b110), 1'b0, 12'hfff, 16'h0000);
    smp.valid = 1'b0;
    chk(words.pt1, 16'h0fff);
    // back-to-back samples on both points
    send(analog_word_pkg::RNG_PM5V, 1'b1, 12'h801, 16'h0000);
    chk(words.pt2, 16'h0fff);
    send(analog_word_pkg::RNG_1_5V, 1'b0, 12'h000, 16'h0000);
    smp.valid = 1'b0;
    chk(words.pt1, 16'h8000);
    chk(words.pt2, 16'h0fff);
    // reset in mid-run clears both words
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(words.pt1 | words.pt2 | {15'h0000, word_upd}, 16'h0000);
    results();
  end
endmodule

`default_nettype wire
